// ### logic/esr_defines.svh
// Constants for the erase/program suspend and resume sequencer
`ifndef ESR_DEFINES_SVH
`define ESR_DEFINES_SVH

// Command codes
`define ESR_CMD_SUSPEND 8'h75
`define ESR_CMD_RESUME 8'h7a
`define ESR_CMD_RD_STATUS 8'h05

// Status byte layout
`define ESR_STAT_BUSY_BIT 0

// Clock and suspend timing
`define ESR_CLK_NS 10
`define ESR_SUSP_MAX_NS 40000
`define ESR_SUSP_CYC (`ESR_SUSP_MAX_NS / `ESR_CLK_NS)

// Latency field encoding: unit code 10b means 8 us, count 00100b
`define ESR_LAT_UNIT 2'b10
`define ESR_LAT_COUNT 5'b00100
`define ESR_LAT_UNIT_NS 8000
`define ESR_LAT_CYC ((`ESR_LAT_COUNT + 1) * `ESR_LAT_UNIT_NS / `ESR_CLK_NS)

// Parameter bytes 2Ch..33h, byte at 2Ch in the low lane
`define ESR_PARAM_FIRST 8'h2c
`define ESR_PARAM_LAST 8'h33
`define ESR_PARAM_BYTES 64'h757a757a_441883cc
`define ESR_PARAM_NONE 8'h00

`endif

// ### logic/esr_pkg.sv
// Types shared by the suspend and resume sequencer
package esr_pkg;

	// One decoded command byte from the serial front end
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} esr_cmd_s;

	// Request to start an array erase or page program
	typedef struct packed {
		logic valid;
		logic is_prog;
		logic [15:0] len;
	} esr_op_s;

	// Sequencer states
	typedef enum logic [1:0] {
		ESR_IDLE,
		ESR_RUN,
		ESR_HALT
	} esr_state_e;

endpackage

// ### logic/esr_seq.sv
// Erase and page program sequencer with suspend and resume
// Operation
// - Erase suspend halts within 40 us
// - Program suspend halts within 40 us
// - Suspend code 75h, resume code 7Ah
// - Suspend applies to the running operation
// - Resume restarts most recently suspended operation
// - Parameter dword twelve reads 44 18 83 CC
// - Latency equals count plus one times unit
// - Bytes 30h..33h read 7A 75 7A 75
// - Status via 05h, bit 0 busy
`timescale 1ns/1ps
`include "esr_defines.svh"

module esr_seq #(
	parameter int OP_W = 16,
	parameter logic [12:0] HALT_CYC = 13'(`ESR_SUSP_CYC)
) (
	input wire logic core_clk, // 100 MHz core clock
	input wire logic rst_b, // Synchronous reset, active low
	input esr_pkg::esr_cmd_s cmd, // Decoded command byte
	input esr_pkg::esr_op_s op, // Erase or program start
	input wire logic [7:0] param_addr, // Parameter byte address
	output logic [7:0] status_byte, // Status captured on 05h
	output logic [7:0] param_data, // Parameter byte read back
	output logic busy, // Operation in progress
	output logic erase_susp, // Erase is suspended
	output logic prog_susp, // Program is suspended
	output logic op_refused, // Start request refused, pulse
	output logic cmd_ignored // Suspend or resume ignored, pulse
);
	import esr_pkg::*;

	// Sequencer state and held operation context
	esr_state_e state_reg; // Current state
	esr_state_e state_next; // Next state
	logic kind_reg; // Running kind, 1 means program
	logic kind_next; // Next running kind
	logic [OP_W-1:0] erem_reg; // Erase work remaining
	logic [OP_W-1:0] erem_next; // Next erase remaining
	logic [OP_W-1:0] prem_reg; // Program work remaining
	logic [OP_W-1:0] prem_next; // Next program remaining
	logic [12:0] halt_reg; // Cycles left to reach halt
	logic [12:0] halt_next; // Next halt count
	logic esus_next; // Next erase suspended flag
	logic psus_next; // Next program suspended flag

	// Command decode
	wire is_susp = cmd.valid && (cmd.code == `ESR_CMD_SUSPEND);
	wire is_res = cmd.valid && (cmd.code == `ESR_CMD_RESUME);
	wire is_rdsr = cmd.valid && (cmd.code == `ESR_CMD_RD_STATUS);

	// Remaining work of whatever is running now
	wire [OP_W-1:0] cur_rem = kind_reg ? prem_reg : erem_reg;
	wire run_done = (state_reg == ESR_RUN) && (cur_rem == OP_W'(1));

	// Completion in the same cycle wins: nothing is left to suspend
	wire susp_take = is_susp && (state_reg == ESR_RUN) && !run_done;

	// Resume needs an idle array and something suspended
	wire any_sus = erase_susp || prog_susp;
	wire res_take = is_res && (state_reg == ESR_IDLE) && any_sus;

	// A suspended erase can never sit on top of a suspended program,
	// so a set program flag always marks the most recent suspend
	wire res_kind = prog_susp;

	// Start guards: the host should never ask, but refuse anyway
	wire erase_ok = !erase_susp && !prog_susp;
	wire prog_ok = !prog_susp;
	wire kind_ok = op.is_prog ? prog_ok : erase_ok;
	wire op_idle = op.valid && (state_reg == ESR_IDLE) && !is_res;
	wire op_take = op_idle && kind_ok;
	wire op_bad = op.valid && !op_take;

	// Halt finishes on the last latency cycle
	wire halt_done = (state_reg == ESR_HALT) && (halt_reg == 13'h0001);

	// Parameter table lookup for bytes 2Ch..33h
	wire param_hit = (param_addr >= `ESR_PARAM_FIRST) &&
		(param_addr <= `ESR_PARAM_LAST);
	wire [7:0] param_off = param_addr - `ESR_PARAM_FIRST;
	wire [2:0] param_idx = param_off[2:0];
	wire [63:0] param_bytes = `ESR_PARAM_BYTES;
	wire [7:0] param_sel = param_hit ?
		param_bytes[{param_idx, 3'b000} +: 8] : `ESR_PARAM_NONE;

	// State transitions
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		case (state_reg)
			ESR_IDLE: begin
				// Resume has priority over a start in the same cycle
				if (res_take) begin
					state_next = ESR_RUN;
					kind_next = res_kind;
				end else if (op_take) begin
					state_next = ESR_RUN;
					kind_next = op.is_prog;
				end
			end
			ESR_RUN: begin
				if (run_done) begin
					state_next = ESR_IDLE;
				end else if (susp_take) begin
					state_next = ESR_HALT;
				end
			end
			ESR_HALT: begin
				// Array quiet, ready for permitted commands
				if (halt_done) begin
					state_next = ESR_IDLE;
				end
			end
			default: begin
				state_next = ESR_IDLE;
			end
		endcase
	end

	// Work counters: loaded on start, frozen while halted or suspended
	always_comb begin
		erem_next = erem_reg;
		prem_next = prem_reg;
		if (op_take && op.is_prog) begin
			prem_next = op.len[OP_W-1:0];
		end else if (op_take) begin
			erem_next = op.len[OP_W-1:0];
		end else if (state_reg == ESR_RUN && !susp_take) begin
			// Keeps counting from where it stopped
			if (kind_reg) begin
				prem_next = prem_reg - OP_W'(1);
			end else begin
				erem_next = erem_reg - OP_W'(1);
			end
		end
	end

	// Halt latency counter
	always_comb begin
		halt_next = halt_reg;
		if (susp_take) begin
			halt_next = HALT_CYC;
		end else if (state_reg == ESR_HALT) begin
			halt_next = halt_reg - 13'h0001;
		end
	end

	// Suspended flags: set at end of halt, cleared by resume
	always_comb begin
		esus_next = erase_susp;
		psus_next = prog_susp;
		if (halt_done && kind_reg) begin
			psus_next = 1'b1;
		end else if (halt_done) begin
			esus_next = 1'b1;
		end else if (res_take && res_kind) begin
			psus_next = 1'b0;
		end else if (res_take) begin
			esus_next = 1'b0;
		end
	end

	// Core state registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_reg <= ESR_IDLE;
			kind_reg <= 1'b0;
			halt_reg <= 13'h0000;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			halt_reg <= halt_next;
		end
	end

	// Work counters
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			erem_reg <= '0;
			prem_reg <= '0;
		end else begin
			erem_reg <= erem_next;
			prem_reg <= prem_next;
		end
	end

	// Registered outputs; busy tracks the next state so it moves
	// in the same edge as the state itself
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			busy <= 1'b0;
			erase_susp <= 1'b0;
			prog_susp <= 1'b0;
			op_refused <= 1'b0;
			cmd_ignored <= 1'b0;
		end else begin
			busy <= (state_next != ESR_IDLE);
			erase_susp <= esus_next;
			prog_susp <= psus_next;
			op_refused <= op_bad;
			cmd_ignored <= (is_susp && !susp_take) ||
				(is_res && !res_take);
		end
	end

	// Status capture on 05h and parameter read-back
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			status_byte <= 8'h00;
			param_data <= `ESR_PARAM_NONE;
		end else begin
			if (is_rdsr) begin
				// Busy as seen by the host at the command
				status_byte <= {7'h00, state_reg != ESR_IDLE};
			end
			param_data <= param_sel;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Cycles spent in halt, read only by the checks
	logic [12:0] halt_age;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			halt_age <= 13'h0000;
		end else if (state_reg == ESR_HALT) begin
			halt_age <= halt_age + 13'h0001;
		end else begin
			halt_age <= 13'h0000;
		end
	end

	localparam int LAT_CYC = `ESR_LAT_CYC;

	sequence s_susp_start;
		susp_take ##1 (state_reg == ESR_HALT);
	endsequence

	sequence s_halt_end;
		halt_done ##1 (state_reg == ESR_IDLE);
	endsequence

	erase_halt_bound_a: assert property (
		(state_reg == ESR_HALT && !kind_reg) |-> halt_age < 13'(LAT_CYC))
		else $error("erase suspend latency exceeded");

	prog_halt_bound_a: assert property (
		(state_reg == ESR_HALT && kind_reg) |-> halt_age < 13'(LAT_CYC))
		else $error("program suspend latency exceeded");

	erase_resume_a: assert property (
		(res_take && erase_susp && !prog_susp) |=>
		(state_reg == ESR_RUN && !kind_reg && !erase_susp))
		else $error("erase resume did not restart erase");

	susp_kind_a: assert property (
		s_susp_start |-> $stable(kind_reg) ##1 $stable(kind_reg))
		else $error("suspend changed running kind");

	resume_recent_a: assert property (
		(res_take && prog_susp) |=> (state_reg == ESR_RUN && kind_reg))
		else $error("resume picked wrong operation");

	dword12_read_a: assert property (
		(param_addr == 8'h2f) |=> (param_data == 8'h44))
		else $error("parameter byte 2Fh wrong");

	latency_calc_a: assert property (
		(state_reg == ESR_HALT) |-> halt_reg <= 13'(LAT_CYC))
		else $error("halt count beyond encoded latency");

	resume_codes_a: assert property (
		(param_addr == 8'h30) |=> (param_data == 8'h7a))
		else $error("parameter byte 30h wrong");

	status_busy_a: assert property (
		(is_rdsr && state_reg != ESR_IDLE) |=> status_byte[0])
		else $error("status busy bit not set");

	halt_freeze_a: assert property (
		s_halt_end |-> $stable(erem_reg) && $stable(prem_reg) && !busy)
		else $error("work counter moved while suspended");

	idle_susp_a: assert property (
		(is_susp && state_reg == ESR_IDLE && !op.valid) |=>
		(state_reg == ESR_IDLE) && $stable(erase_susp) && cmd_ignored)
		else $error("idle suspend not ignored");

endmodule

// ### tb/esr_host.sv
// Host side model issuing commands and start requests
`timescale 1ns/1ps

module esr_host (
	input wire logic core_clk, // Core clock
	output esr_pkg::esr_cmd_s cmd, // Command byte to device
	output esr_pkg::esr_op_s op // Start request to device
);
	import esr_pkg::*;
	int cyc = 0; // Free running cycle count
	int last_res = -20000; // Cycle of the latest resume

	// Cycle count for the resume to suspend spacing
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
	end

	// Quiet bus at time zero
	initial begin
		cmd = '0;
		op = '0;
	end

	// One command byte, held for one taking edge
	task automatic send(input logic [7:0] code);
		@(posedge core_clk) #1;
		// 128 us is 12800 cycles at 10 ns
		while (code == 8'h75 && cyc - last_res < 12800) begin
			@(posedge core_clk) #1;
		end
		cmd.valid = 1'b1;
		cmd.code = code;
		@(posedge core_clk) #1;
		if (code == 8'h7a) begin
			last_res = cyc;
		end
		cmd.valid = 1'b0;
		// Released lane must not keep showing the last byte
		cmd.code = ~code;
	endtask

	// One start request; the bench decides if it is a forbidden one
	task automatic start(input logic is_prog, input logic [15:0] len);
		@(posedge core_clk) #1;
		op = '{valid: 1'b1, is_prog: is_prog, len: len};
		@(posedge core_clk) #1;
		op.valid = 1'b0;
	endtask
endmodule

// ### tb/test_erase_program_suspend_resume.sv
// Self-checking bench for the suspend and resume sequencer
`timescale 1ns/1ps

module test_erase_program_suspend_resume;
	import esr_pkg::*;
	localparam int HALT = 3; // Shortened suspend latency
	logic core_clk = 1'b0; // Core clock
	logic rst_b = 1'b0; // Reset, active low
	logic [7:0] param_addr = 8'h00; // Parameter byte address
	esr_cmd_s cmd; // From host model
	esr_op_s op; // From host model
	logic [7:0] status_byte, param_data;
	logic busy, erase_susp, prog_susp, op_refused, cmd_ignored;
	int mismatches = 0;
	int total_checks = 0;

	esr_host host (.core_clk(core_clk), .cmd(cmd), .op(op));

	esr_seq #(.HALT_CYC(13'(HALT))) DUT (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.cmd(cmd),
		.op(op),
		.param_addr(param_addr),
		.status_byte(status_byte),
		.param_data(param_data),
		.busy(busy),
		.erase_susp(erase_susp),
		.prog_susp(prog_susp),
		.op_refused(op_refused),
		.cmd_ignored(cmd_ignored)
	);

	// Clock, 10 ns period
	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// Shared compare, four-state safe
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for busy to drop; n is edges waited
	task automatic wait_idle(input int limit, output int n);
		n = 0;
		while (busy !== 1'b0 && n <= limit) begin
			@(posedge core_clk) #1;
			n++;
		end
	endtask

	// Parameter bytes, one address past the table too
	task automatic t_params();
		logic [7:0] exp [9] = '{8'hcc, 8'h83, 8'h18, 8'h44, 8'h7a,
			8'h75, 8'h7a, 8'h75, 8'h00};
		check("reset", 0, {busy, erase_susp, prog_susp});
		for (int i = 0; i < 9; i++) begin
			@(posedge core_clk) #1;
			param_addr = 8'h2c + 8'(i);
			@(posedge core_clk) #1;
			check("param_data", 16'(exp[i]), 16'(param_data));
		end
		$display("test params done");
	endtask

	// Erase suspend, forbidden erase, resume to completion
	task automatic t_erase();
		int n;
		host.send(8'h75);
		check("idle ignored", 1, cmd_ignored);
		host.start(1'b0, 16'd40);
		check("busy", 1, busy);
		host.send(8'h75);
		wait_idle(HALT, n);
		check("erase halt", 1, n <= HALT);
		check("erase_susp", 1, erase_susp);
		host.send(8'h05);
		check("status idle", 0, status_byte);
		host.start(1'b0, 16'd5);
		check("erase refused", 1, op_refused);
		host.send(8'h7a);
		check("erase resume", 2, {busy, erase_susp});
		wait_idle(40, n);
		check("erase finish", 1, n > 0 && n <= 40);
		$display("test erase done");
	endtask

	// Program suspend, forbidden starts, spaced second suspend
	task automatic t_prog();
		int n;
		host.start(1'b1, 16'd30000);
		host.send(8'h05);
		check("status busy", 1, status_byte);
		host.send(8'h75);
		wait_idle(HALT, n);
		check("prog halt", 1, prog_susp && n <= HALT);
		host.start(1'b1, 16'd5);
		check("prog refused", 1, op_refused);
		host.start(1'b0, 16'd5);
		check("erase refused", 1, op_refused);
		host.send(8'h7a);
		check("prog resume", 2, {busy, prog_susp});
		host.send(8'h75);
		wait_idle(HALT, n);
		check("prog again", 1, prog_susp && n <= HALT);
		host.send(8'h7a);
		wait_idle(30000, n);
		check("prog finish", 0, {busy, prog_susp});
		$display("test prog done");
	endtask

	// Stacked suspends, resume order, then reset in mid-run
	task automatic t_reset();
		int n;
		host.start(1'b0, 16'd30000);
		host.send(8'h75);
		wait_idle(HALT, n);
		host.start(1'b1, 16'd30000);
		host.send(8'h75);
		wait_idle(HALT, n);
		check("stack susp", 3, {busy, erase_susp, prog_susp});
		host.send(8'h7a);
		check("stack resume", 6, {busy, erase_susp, prog_susp});
		// Reset lands while the program runs over a held erase
		rst_b = 1'b0;
		repeat (2) @(posedge core_clk) #1;
		check("reset mid", 0, {status_byte, busy, erase_susp, prog_susp,
			op_refused, cmd_ignored});
		rst_b = 1'b1;
		@(posedge core_clk) #1;
		check("release", 0, {busy, erase_susp, prog_susp});
		// A fresh erase is only taken if the held erase was dropped
		host.start(1'b0, 16'd3);
		wait_idle(5, n);
		check("erase after reset", 3, n);
		$display("test reset done");
	endtask

	// Counts, verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence after six reset cycles
	initial begin
		repeat (6) @(posedge core_clk);
		#1 rst_b = 1'b1;
		t_params();
		t_erase();
		t_prog();
		t_reset();
		test_done();
	end

	// Watchdog, over twice the expected run
	initial begin
		#800000;
		mismatches++;
		test_done();
	end
endmodule
